// ==== mdm_defs.vh ====
// constants for the clause 22 management slave
// included by the management slave file; definitions only
`ifndef MDM_DEFS_VH
`define MDM_DEFS_VH
`define MDM_OP_WRITE 2'h1
`define MDM_OP_READ 2'h2
`define MDM_ST 2'h1
`define MDM_BCAST_PHY 5'h00
`define MDM_REG_CONTROL 5'h00
`define MDM_REG_STATUS 5'h01
`define MDM_REG_ID_HIGH 5'h02
`define MDM_REG_ID_LOW 5'h03
`define MDM_REG_ADVERT 5'h04
`define MDM_REG_PARTNER 5'h05
`define MDM_REG_EXPANSION 5'h06
`define MDM_REG_NP_TX 5'h07
`define MDM_REG_NP_RX 5'h08
`define MDM_REG_EXT_STATUS 5'h0F
`define MDM_REG_IRQ_CTRL 5'h10
`define MDM_CTRL_RESET_VAL 16'h1540
`define MDM_CTRL_WMASK 16'hDE20
`define MDM_CTRL_FIXED 16'h0140
`define MDM_CTRL_SOFT_RST 15
`define MDM_CTRL_RESTART_AN 9
`define MDM_CTRL_SELF_CLR 16'h8200
`define MDM_IRQ_STATUS_MASK 16'h0002
`define MDM_ADVERT_RESET_VAL 16'h0020
`define MDM_NP_TX_RESET_VAL 16'h0000
`define MDM_IRQ_RESET_VAL 16'h0000
`define MDM_IRQ_WMASK 16'h0003
`define MDM_IRQ_STATUS_BIT 1
`define MDM_PRE_MIN 5'h01
`define MDM_CNT_ST 6'h01
`define MDM_CNT_OP 6'h03
`define MDM_CNT_PHY 6'h08
`define MDM_CNT_REG 6'h0D
`define MDM_CNT_TA1 6'h0E
`define MDM_CNT_TA2 6'h0F
`define MDM_CNT_END 6'h1F
`endif

// ==== mdm_sync_edge.v ====
// two-flop synchroniser with rising edge detect for the management clock
// assumes the clock input is asynchronous to clk
`timescale 1ns/1ns
module mdm_sync_edge (
  input wire clk, // system clock
  input wire rst, // synchronous reset, high
  input wire din, // asynchronous input
  output reg level, // synchronised level
  output reg rise // one-cycle pulse on rising edge
);
  reg meta_r;
  reg lastLevel_r;
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      level <= 1'b0;
      lastLevel_r <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta_r <= din;
      level <= meta_r;
      lastLevel_r <= level;
      rise <= level & ~lastLevel_r;
    end
  end
endmodule // mdm_sync_edge

// ==== mdm_mdio_slave.v ====
// clause 22 management slave with the PCS management register set
// assumes an external three-state buffer joins mdioIn, mdioOut, mdioOe
`timescale 1ns/1ns
`include "mdm_defs.vh"
module mdm_mdio_slave #(
  parameter [4:0] PHY_ADDR = 5'h01, // configured physical address
  parameter [15:0] ID_HIGH = 16'h0000, // identifier word, arbitrary value
  parameter [15:0] ID_LOW = 16'h0000 // identifier word, arbitrary value
) (
  input wire mclk, // system clock
  input wire sys_rst, // synchronous hard reset
  input wire clock_lock_reset, // clock-lock loss reset, high
  input wire mdc, // management clock pin
  input wire mdioIn, // management data from line
  output reg mdioOut, // management data to line
  output reg mdioOe, // high while driving the line
  input wire [15:0] pcsStatus, // live status word
  input wire [15:0] partnerAbility, // partner base ability
  input wire [15:0] expansion, // negotiation expansion
  input wire [15:0] npReceive, // next page received
  input wire [15:0] extStatus, // extended status
  input wire irqEvent, // negotiation complete event
  output reg [15:0] controlOut, // control register value
  output reg [15:0] advertOut, // advertisement register value
  output reg [15:0] npTransmitOut, // next page transmit value
  output reg restartAn, // restart negotiation pulse
  output reg irqEnable, // negotiation interrupt enable
  output reg irqPending // negotiation interrupt status
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HDR = 4'h2;
  localparam [3:0] S_DATA = 4'h4;
  localparam [3:0] S_WAIT = 4'h8;

  wire mdcLevel;
  wire mdcRise;
  reg dMeta_r;
  reg dSync_r;
  reg [3:0] state_r;
  reg [4:0] preCnt_r;
  reg [5:0] bitCnt_r;
  reg [13:0] hdr_r;
  reg [15:0] data_r;
  reg [15:0] rdData;
  reg wrStrobe_r;
  reg [4:0] wrAddr_r;
  reg [15:0] wrData_r;
  reg softRst_r;
  reg [15:0] irqReg_r;
  wire anyRst = sys_rst | clock_lock_reset | softRst_r;

  mdm_sync_edge uMdcSync (
    .clk(mclk),
    .rst(sys_rst),
    .din(mdc),
    .level(mdcLevel),
    .rise(mdcRise)
  );

  // data line synchronised alongside the clock to keep equal latency
  always @(posedge mclk) begin
    if (sys_rst) begin
      dMeta_r <= 1'b1;
      dSync_r <= 1'b1;
    end else begin
      dMeta_r <= mdioIn;
      dSync_r <= dMeta_r;
    end
  end

  function addressed;
    input [4:0] phy;
    begin
      addressed = (phy == PHY_ADDR) || (phy == `MDM_BCAST_PHY);
    end
  endfunction

  // header layout: [13:12] start, [11:10] op, [9:5] phy, [4:0] reg
  wire [1:0] hOp = hdr_r[11:10];
  wire [4:0] hPhy = hdr_r[9:5];
  wire [4:0] hReg = hdr_r[4:0];
  wire isRead = (hOp == `MDM_OP_READ) && addressed(hPhy);
  wire isWrite = (hOp == `MDM_OP_WRITE) && addressed(hPhy);

  // register decode, same map for either fibre rate
  always @* begin
    rdData = 16'h0000;
    case (hReg)
      `MDM_REG_CONTROL: rdData = controlOut;
      `MDM_REG_STATUS: rdData = pcsStatus;
      `MDM_REG_ID_HIGH: rdData = ID_HIGH;
      `MDM_REG_ID_LOW: rdData = ID_LOW;
      `MDM_REG_ADVERT: rdData = advertOut;
      `MDM_REG_PARTNER: rdData = partnerAbility;
      `MDM_REG_EXPANSION: rdData = expansion;
      `MDM_REG_NP_TX: rdData = npTransmitOut;
      `MDM_REG_NP_RX: rdData = npReceive;
      `MDM_REG_EXT_STATUS: rdData = extStatus;
      `MDM_REG_IRQ_CTRL: rdData = irqReg_r;
      default: rdData = 16'h0000;
    endcase
  end

  // bits sampled on mdc rising edge; output changes on the same edge,
  // giving the master nearly a full mdc period of setup
  always @(posedge mclk) begin
    if (sys_rst | clock_lock_reset) begin
      state_r <= S_IDLE;
      preCnt_r <= 5'h00;
      bitCnt_r <= 6'h00;
      hdr_r <= 14'h0000;
      data_r <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
      wrStrobe_r <= 1'b0;
      wrAddr_r <= 5'h00;
      wrData_r <= 16'h0000;
    end else begin
      wrStrobe_r <= 1'b0;
      if (mdcRise) begin
        case (state_r)
          S_IDLE: begin
            if (dSync_r) begin
              if (preCnt_r != 5'h1F)
                preCnt_r <= preCnt_r + 5'h01;
            end else begin
              // zero after preamble is the first start bit
              if (preCnt_r >= `MDM_PRE_MIN) begin
                state_r <= S_HDR;
                hdr_r <= 14'h0000;
                bitCnt_r <= 6'h01;
              end
              preCnt_r <= 5'h00;
            end
          end
          S_HDR: begin
            hdr_r <= {hdr_r[12:0], dSync_r};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (bitCnt_r == `MDM_CNT_ST && dSync_r != 1'b1) begin
              state_r <= S_IDLE; // bad start, drop frame
            end else if (bitCnt_r == `MDM_CNT_REG) begin
              state_r <= S_DATA;
            end
          end
          S_DATA: begin
            bitCnt_r <= bitCnt_r + 6'h01;
            data_r <= {data_r[14:0], dSync_r};
            if (bitCnt_r == `MDM_CNT_TA1 && isRead) begin
              mdioOe <= 1'b1;
              mdioOut <= 1'b0;
              data_r <= rdData;
            end else if (bitCnt_r >= `MDM_CNT_TA2 && isRead) begin
              mdioOut <= data_r[15];
              data_r <= {data_r[14:0], 1'b0};
            end
            if (bitCnt_r == `MDM_CNT_END) begin
              mdioOe <= 1'b0;
              if (isWrite) begin
                wrStrobe_r <= 1'b1;
                wrAddr_r <= hReg;
                wrData_r <= {data_r[14:0], dSync_r};
              end
              state_r <= isRead ? S_WAIT : S_IDLE;
              preCnt_r <= 5'h00;
            end
          end
          S_WAIT: begin
            // drive already ends on the final count edge; this edge only counts the idle bit
            mdioOe <= 1'b0;
            preCnt_r <= dSync_r ? 5'h01 : 5'h00;
            state_r <= S_IDLE;
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // management registers; soft reset self-clears via anyRst
  always @(posedge mclk) begin
    if (anyRst) begin
      controlOut <= `MDM_CTRL_RESET_VAL;
      advertOut <= `MDM_ADVERT_RESET_VAL;
      npTransmitOut <= `MDM_NP_TX_RESET_VAL;
      irqReg_r <= `MDM_IRQ_RESET_VAL;
      restartAn <= 1'b0;
      softRst_r <= 1'b0;
      irqEnable <= 1'b0;
      irqPending <= 1'b0;
    end else begin
      restartAn <= 1'b0;
      if (wrStrobe_r) begin
        case (wrAddr_r)
          `MDM_REG_CONTROL: begin
            controlOut <= (wrData_r & `MDM_CTRL_WMASK & ~(`MDM_CTRL_SELF_CLR))
              | `MDM_CTRL_FIXED;
            softRst_r <= wrData_r[`MDM_CTRL_SOFT_RST];
            restartAn <= wrData_r[`MDM_CTRL_RESTART_AN];
          end
          `MDM_REG_ADVERT: advertOut <= wrData_r;
          `MDM_REG_NP_TX: npTransmitOut <= wrData_r;
          `MDM_REG_IRQ_CTRL: begin
            // event in the clearing cycle keeps the status set
            irqReg_r <= ((wrData_r & `MDM_IRQ_WMASK)
              | (irqEvent ? `MDM_IRQ_STATUS_MASK : 16'h0000));
            irqEnable <= wrData_r[0];
            irqPending <= wrData_r[`MDM_IRQ_STATUS_BIT] | irqEvent;
          end
          default: ;
        endcase
      end else if (irqEvent) begin
        irqReg_r[`MDM_IRQ_STATUS_BIT] <= 1'b1;
        irqPending <= 1'b1;
      end
    end
  end
endmodule // mdm_mdio_slave

// ==== mdm_slave_assertions.sv ====
// port checker for the management slave
// bound from tb; sees slave ports only
`timescale 1ns/1ns
module mdm_slave_chk (
  input wire mclk, // clock
  input wire sys_rst, // reset
  input wire clock_lock_reset, // lock reset
  input wire mdc, // mgmt clock
  input wire mdioOut, // line out
  input wire mdioOe, // line enable
  input wire [15:0] controlOut, // reg 0
  input wire [15:0] advertOut, // reg 4
  input wire restartAn, // pulse
  input wire irqEvent, // event
  input wire irqPending // status
);
  reg mdcQ_r;
  reg [7:0] sinceRise_r;
  reg [7:0] oeLen_r;
  // raw mdc age; slave reacts a few cycles after through its sync flops
  always @(posedge mclk) begin
    mdcQ_r <= mdc;
    sinceRise_r <= (mdc && !mdcQ_r) ? 8'h00 : sinceRise_r + {7'h00, sinceRise_r != 8'hFF};
    oeLen_r <= mdioOe ? oeLen_r + 8'h01 : 8'h00;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || clock_lock_reset);
  a_reset_vals: assert property (disable iff (1'b0) (sys_rst || clock_lock_reset) |=>
    controlOut == 16'h1540 && advertOut == 16'h0020 && !mdioOe) else $error("bad reset");
  a_ctrl_fixed: assert property ((controlOut & 16'h21DF) == 16'h0140)
    else $error("control fixed bits");
  a_restart_once: assert property (restartAn |=> !restartAn) else $error("restart");
  a_oe_after_mdc: assert property ($rose(mdioOe) |-> sinceRise_r < 8'h0A)
    else $error("drive without clock");
  a_turn_zero: assert property ($rose(mdioOe) |-> !mdioOut) else $error("turn bit");
  a_oe_span: assert property ($fell(mdioOe) |-> oeLen_r > 8'h80 && oeLen_r < 8'h98)
    else $error("drive span");
  a_out_timing: assert property ($changed(mdioOut) |-> sinceRise_r < 8'h0A)
    else $error("data off clock");
  a_irq_set: assert property (irqEvent |-> ##[1:2] irqPending) else $error("irq");
  cover property ($rose(mdioOe));
  cover property (restartAn);
  cover property ($rose(irqPending));
endmodule // mdm_slave_chk

// ==== mdm_master_model.sv ====
// management master model, 80 ns bit time
// tb resolves the line with a pull-up
`timescale 1ns/1ns
module mdm_master_model (
  output reg mdc, // mgmt clock
  output reg mOe, // master drives
  output reg mOut, // master data
  input wire line // resolved line
);
  initial begin
    mdc = 1'b0;
    mOe = 1'b0;
    mOut = 1'b1;
  end
  // mdc stands low between frames; one released idle bit ends each
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
    output [15:0] rd);
    reg [64:0] bits;
    integer i;
    begin
      bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd, 1'b1};
      rd = 16'h0000;
      for (i = 64; i >= 0; i = i - 1) begin
        mOe = (i > 18) || (op != 2'h2 && i > 0);
        mOut = bits[i];
        #40 mdc = 1'b1;
        if (i < 17 && i > 0) rd = {rd[14:0], line};
        #40 mdc = 1'b0;
      end
      mOe = 1'b0;
    end
  endtask
endmodule // mdm_master_model

// ==== tb.sv ====
// top test: slave at address 1 driven by the master model
// status words tied to distinct patterns
`timescale 1ns/1ns
module tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg lockRst = 1'b0;
  reg irqEv = 1'b0;
  reg sawRestart = 1'b0;
  reg [15:0] rd;
  integer mismatches = 0;
  integer n_checks = 0;
  wire mdc, mOe, mOut, sOut, sOe, rAn, irqEn, irqP;
  wire [15:0] ctl, adv, npt;
  wire line = !((sOe && !sOut) || (mOe && !mOut));
  mdm_master_model mm (.mdc(mdc), .mOe(mOe), .mOut(mOut), .line(line));
  mdm_mdio_slave uut (.mclk(mclk), .sys_rst(sys_rst), .clock_lock_reset(lockRst),
    .mdc(mdc), .mdioIn(line), .mdioOut(sOut), .mdioOe(sOe), .pcsStatus(16'h1111),
    .partnerAbility(16'h2222), .expansion(16'h3333), .npReceive(16'h4444),
    .extStatus(16'h5555), .irqEvent(irqEv), .controlOut(ctl), .advertOut(adv),
    .npTransmitOut(npt), .restartAn(rAn), .irqEnable(irqEn), .irqPending(irqP));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (rAn) sawRestart <= 1'b1;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] pa, input [4:0] ra, input [15:0] d);
    begin
      mm.frame(2'h1, pa, ra, d, rd);
      repeat (4) @(negedge mclk);
    end
  endtask
  task rdc(input [4:0] pa, input [4:0] ra, input [15:0] exp);
    begin
      mm.frame(2'h2, pa, ra, 16'h0000, rd);
      chk(rd, exp);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    rdc(5'h01, 5'h00, 16'h1540);
    rdc(5'h01, 5'h04, 16'h0020);
    wr(5'h01, 5'h04, 16'hABCD);
    chk(adv, 16'hABCD);
    rdc(5'h00, 5'h04, 16'hABCD);
    wr(5'h00, 5'h07, 16'h5A5A);
    chk(npt, 16'h5A5A);
    wr(5'h02, 5'h04, 16'h0000);
    rdc(5'h02, 5'h04, 16'hFFFF);
    chk(adv, 16'hABCD);
    wr(5'h01, 5'h01, 16'h0000);
    rdc(5'h01, 5'h01, 16'h1111);
    rdc(5'h01, 5'h02, 16'h0000);
    rdc(5'h01, 5'h05, 16'h2222);
    rdc(5'h01, 5'h06, 16'h3333);
    rdc(5'h01, 5'h08, 16'h4444);
    rdc(5'h01, 5'h0F, 16'h5555);
    wr(5'h01, 5'h09, 16'hFFFF);
    rdc(5'h01, 5'h09, 16'h0000);
    rdc(5'h01, 5'h1F, 16'h0000);
    wr(5'h01, 5'h00, 16'h0E20);
    chk({15'h0000, sawRestart}, 16'h0001);
    rdc(5'h01, 5'h00, 16'h0D60);
    wr(5'h01, 5'h00, 16'h8000);
    rdc(5'h01, 5'h00, 16'h1540);
    wr(5'h01, 5'h04, 16'h1234);
    lockRst = 1'b1;
    repeat (4) @(negedge mclk);
    lockRst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(adv, 16'h0020);
    irqEv = 1'b1;
    @(negedge mclk);
    irqEv = 1'b0;
    rdc(5'h01, 5'h10, 16'h0002);
    wr(5'h01, 5'h10, 16'h0001);
    chk({14'h0000, irqEn, irqP}, 16'h0002);
    final_report;
  end
endmodule // tb
bind mdm_mdio_slave mdm_slave_chk chk (.*);
